// ---- rtl/tam_monitor.sv ----
/*
 cabinet temperature monitor with alarm: menu, logs, calibration, alarm
 timing, relay and audible drive, and an axi4-lite register slave.
 assumes buttons, switches and the sensor word are synchronous to aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_monitor #(
	parameter int TICK_CYCLES = tam_pkg::SEC_CYCLES // cycles per one-second tick
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic button_set, // set button, high while pressed
	input wire logic button_up, // up button
	input wire logic button_down, // down button
	input wire logic button_reset, // reset button
	input wire logic [3:0] option_sw, // option switches one to four, high is on
	input wire logic signed [9:0] sensor_temp, // sensed temperature, degrees
	input wire logic sensor_valid, // sensor word strobe
	input wire logic battery_low, // backup battery low or absent
	input wire logic mains_lost, // main power lost
	output logic signed [9:0] display_value, // value shown
	output logic [2:0] display_item, // item shown, menu order
	output logic display_blank, // display dark phase of a flash
	output logic display_on, // display powered on
	output logic battery_dots, // three bottom dots
	output logic relay_drive, // alarm relay
	output logic audible_drive // audible alarm drive
);
	typedef struct packed {
		logic [26:0] tick_cnt;
		logic tick;
		logic flash_phase;
		logic [3:0] btn_prev;
		logic [3:0] sw_press;
		tam_pkg::tam_menu_e menu;
		tam_pkg::tam_temp_t upper;
		tam_pkg::tam_temp_t lower;
		tam_pkg::tam_temp_t cal;
		tam_pkg::tam_temp_t ed_upper;
		tam_pkg::tam_temp_t ed_lower;
		tam_pkg::tam_temp_t ed_cal;
		tam_pkg::tam_temp_t temp;
		tam_pkg::tam_temp_t peak;
		tam_pkg::tam_temp_t minimum;
		logic alarm;
		logic silenced;
		logic power_show;
		tam_pkg::tam_temp_t display_value;
		logic display_blank;
		logic display_on;
		logic battery;
		logic relay;
		logic audible;
		logic aw_held;
		logic [7:0] awaddr_h;
		logic w_held;
		logic [31:0] wdata_h;
		logic [3:0] wstrb_h;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tam_state_s;

	tam_state_s r;
	tam_state_s n;
	logic menu_idle_done;
	logic delay_done;
	logic silence_done;
	logic out_of_range;
	logic disabled;
	logic in_menu;

	// limit a wide sum to the displayable range
	function automatic tam_pkg::tam_temp_t clamp_temp(input logic signed [10:0] v);
		logic signed [10:0] lo;
		logic signed [10:0] hi;
		lo = 11'(tam_pkg::TEMP_MIN);
		hi = 11'(tam_pkg::TEMP_MAX);
		if (v > hi)
			clamp_temp = tam_pkg::TEMP_MAX;
		else if (v < lo)
			clamp_temp = tam_pkg::TEMP_MIN;
		else
			clamp_temp = v[9:0];
	endfunction

	// one step up or down, held inside lo..hi
	function automatic tam_pkg::tam_temp_t step_value(input tam_pkg::tam_temp_t v,
		input logic up, input logic down, input tam_pkg::tam_temp_t lo,
		input tam_pkg::tam_temp_t hi);
		step_value = v;
		if (up && v < hi)
			step_value = v + 10'sd1;
		else if (down && v > lo)
			step_value = v - 10'sd1;
	endfunction

	// sign-extend a temperature onto the data bus
	function automatic logic [31:0] sext32(input tam_pkg::tam_temp_t v);
		sext32 = {{22{v[9]}}, v};
	endfunction

	// word match on the register address
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
		addr_is = (a[7:2] == off[7:2]);
	endfunction

	// alarm conditions from committed thresholds and switches
	assign out_of_range = (r.temp > r.upper) || (r.temp < r.lower);
	assign disabled = option_sw[tam_pkg::SW_SIL_LONG] && option_sw[tam_pkg::SW_SIL_SHORT];
	assign in_menu = (r.menu != tam_pkg::SHOW_TEMP) && (r.menu != tam_pkg::SHOW_CONFIRM);

	// menu inactivity timer, cleared while any panel button is held
	tam_sec_timer u_menu_timer (
		.clk(aclk),
		.rst_n(aresetn),
		.tick(r.tick),
		.run(in_menu && (r.btn_prev == 4'h0)),
		.limit(tam_pkg::MENU_IDLE_TICKS),
		.done(menu_idle_done)
	);

	// alarm delay timer runs while out of range with delay selected
	tam_sec_timer u_delay_timer (
		.clk(aclk),
		.rst_n(aresetn),
		.tick(r.tick),
		.run(out_of_range && !disabled && option_sw[tam_pkg::SW_DELAY]),
		.limit(tam_pkg::ALARM_DELAY_TICKS),
		.done(delay_done)
	);

	// audible silence timer, 5 or 45 minutes
	tam_sec_timer u_silence_timer (
		.clk(aclk),
		.rst_n(aresetn),
		.tick(r.tick),
		.run(r.alarm && !r.silenced && (option_sw[tam_pkg::SW_SIL_LONG]
			^ option_sw[tam_pkg::SW_SIL_SHORT])),
		.limit(option_sw[tam_pkg::SW_SIL_LONG] ? tam_pkg::SILENCE_LONG_TICKS
			: tam_pkg::SILENCE_SHORT_TICKS),
		.done(silence_done)
	);

	// next-state logic for the whole block
	always_comb
	begin
		logic [3:0] buttons;
		logic [3:0] press;
		logic signed [10:0] sum;
		tam_pkg::tam_temp_t sample;
		logic trigger;
		logic clear;
		logic aw_take;
		logic w_take;
		logic ar_take;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		buttons = {button_reset, button_down, button_up, button_set};
		press = (buttons & ~r.btn_prev) | r.sw_press;
		sum = 11'(sensor_temp) + 11'(r.cal);
		sample = clamp_temp(sum);
		trigger = 1'b0;
		clear = 1'b0;
		aw_take = s_axi_awvalid && s_axi_awready;
		w_take = s_axi_wvalid && s_axi_wready;
		ar_take = s_axi_arvalid && s_axi_arready;
		waddr = r.aw_held ? r.awaddr_h : s_axi_awaddr;
		wdata = r.w_held ? r.wdata_h : s_axi_wdata;
		wstrb = r.w_held ? r.wstrb_h : s_axi_wstrb;
		n = r;
		n.btn_prev = buttons;
		n.sw_press = 4'h0;

		// one-second tick and flash phase
		n.tick = 1'b0;
		if (r.tick_cnt == 27'(TICK_CYCLES - 1))
		begin
			n.tick_cnt = '0;
			n.tick = 1'b1;
			n.flash_phase = ~r.flash_phase;
		end
		else
			n.tick_cnt = r.tick_cnt + 27'h1;

		// calibrated temperature
		if (sensor_valid)
			n.temp = sample;

		// peak and minimum logs, reloaded from the present temperature on reset
		if (press[tam_pkg::PRESS_RESET])
		begin
			n.peak = r.temp;
			n.minimum = r.temp;
		end
		else if (sensor_valid)
		begin
			if (sample > r.peak)
				n.peak = sample;
			if (sample < r.minimum)
				n.minimum = sample;
		end

		// menu walk; edits stay in shadow copies until the sequence completes
		case (r.menu)
			tam_pkg::SHOW_TEMP:
				if (press[tam_pkg::PRESS_SET])
				begin
					n.menu = tam_pkg::SHOW_UPPER;
					n.ed_upper = r.upper;
					n.ed_lower = r.lower;
					n.ed_cal = r.cal;
				end
			tam_pkg::SHOW_UPPER:
			begin
				n.ed_upper = step_value(r.ed_upper, press[tam_pkg::PRESS_UP],
					press[tam_pkg::PRESS_DOWN], tam_pkg::TEMP_MIN, tam_pkg::TEMP_MAX);
				if (press[tam_pkg::PRESS_SET])
					n.menu = tam_pkg::SHOW_LOWER;
			end
			tam_pkg::SHOW_LOWER:
			begin
				n.ed_lower = step_value(r.ed_lower, press[tam_pkg::PRESS_UP],
					press[tam_pkg::PRESS_DOWN], tam_pkg::TEMP_MIN, tam_pkg::TEMP_MAX);
				if (press[tam_pkg::PRESS_SET])
					n.menu = tam_pkg::SHOW_PEAK;
			end
			tam_pkg::SHOW_PEAK:
				if (press[tam_pkg::PRESS_SET])
					n.menu = tam_pkg::SHOW_MIN;
			tam_pkg::SHOW_MIN:
				if (press[tam_pkg::PRESS_SET])
					n.menu = tam_pkg::SHOW_CAL;
			tam_pkg::SHOW_CAL:
			begin
				n.ed_cal = step_value(r.ed_cal, press[tam_pkg::PRESS_UP],
					press[tam_pkg::PRESS_DOWN], tam_pkg::CAL_MIN, tam_pkg::CAL_MAX);
				if (press[tam_pkg::PRESS_SET])
				begin
					n.menu = tam_pkg::SHOW_CONFIRM;
					n.upper = r.ed_upper;
					n.lower = r.ed_lower;
					n.cal = r.ed_cal;
				end
			end
			tam_pkg::SHOW_CONFIRM:
				if (r.tick)
					n.menu = tam_pkg::SHOW_TEMP;
			default:
				n.menu = tam_pkg::SHOW_TEMP;
		endcase

		// idle timeout leaves the menu; shadows are simply never committed
		if (in_menu && menu_idle_done && (press == 4'h0))
			n.menu = tam_pkg::SHOW_TEMP;

		// alarm latch: a trigger wins over a clear in the same cycle
		trigger = out_of_range && !disabled
			&& (!option_sw[tam_pkg::SW_DELAY] || delay_done);
		if (disabled)
			clear = 1'b1;
		else if (!option_sw[tam_pkg::SW_MANUAL])
			clear = !out_of_range;
		else
			clear = press[tam_pkg::PRESS_RESET];
		if (trigger)
			n.alarm = 1'b1;
		else if (clear)
			n.alarm = 1'b0;

		// audible silencing by reset press or silence timer
		if (r.alarm && press[tam_pkg::PRESS_RESET])
			n.silenced = 1'b1;
		else if (silence_done)
			n.silenced = 1'b1;
		else if (!r.alarm)
			n.silenced = 1'b0;

		// power-out display latch
		if (!mains_lost)
			n.power_show = 1'b0;
		else if (press[tam_pkg::PRESS_RESET])
			n.power_show = 1'b1;

		// registered panel outputs
		case (r.menu)
			tam_pkg::SHOW_UPPER: n.display_value = r.ed_upper;
			tam_pkg::SHOW_LOWER: n.display_value = r.ed_lower;
			tam_pkg::SHOW_PEAK: n.display_value = r.peak;
			tam_pkg::SHOW_MIN: n.display_value = r.minimum;
			tam_pkg::SHOW_CAL: n.display_value = r.ed_cal;
			default: n.display_value = r.temp;
		endcase
		n.display_blank = (r.menu == tam_pkg::SHOW_CONFIRM)
			|| (r.alarm && !disabled && r.flash_phase);
		n.display_on = !mains_lost || r.power_show;
		n.battery = battery_low;
		n.relay = r.alarm && !disabled;
		n.audible = (r.alarm && !r.silenced && !disabled) || r.power_show;

		// axi write: address and data taken in either order
		if (r.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (aw_take)
		begin
			n.aw_held = 1'b1;
			n.awaddr_h = s_axi_awaddr;
		end
		if (w_take)
		begin
			n.w_held = 1'b1;
			n.wdata_h = s_axi_wdata;
			n.wstrb_h = s_axi_wstrb;
		end
		if ((r.aw_held || aw_take) && (r.w_held || w_take))
		begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = tam_pkg::RESP_SLVERR;
			if (addr_is(waddr, tam_pkg::CTRL_OFF))
			begin
				n.bresp = tam_pkg::RESP_OKAY;
				if (wstrb[0])
					n.sw_press = wdata[3:0];
			end
		end

		// axi read: one word, answered on the next cycle
		if (r.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (ar_take)
		begin
			n.rvalid = 1'b1;
			n.rresp = tam_pkg::RESP_OKAY;
			n.rdata = 32'h0;
			if (addr_is(s_axi_araddr, tam_pkg::STATUS_OFF))
			begin
				n.rdata[tam_pkg::ST_ALARM] = r.alarm;
				n.rdata[tam_pkg::ST_AUDIBLE] = r.audible;
				n.rdata[tam_pkg::ST_SILENCED] = r.silenced;
				n.rdata[tam_pkg::ST_OUT_RANGE] = out_of_range;
				n.rdata[tam_pkg::ST_ITEM_LSB +: 3] = r.menu;
				n.rdata[tam_pkg::ST_MAINS_LOST] = mains_lost;
				n.rdata[tam_pkg::ST_POWER_SHOW] = r.power_show;
				n.rdata[tam_pkg::ST_BATTERY] = r.battery;
			end
			else if (addr_is(s_axi_araddr, tam_pkg::TEMP_OFF))
				n.rdata = sext32(r.temp);
			else if (addr_is(s_axi_araddr, tam_pkg::UPPER_OFF))
				n.rdata = sext32(r.upper);
			else if (addr_is(s_axi_araddr, tam_pkg::LOWER_OFF))
				n.rdata = sext32(r.lower);
			else if (addr_is(s_axi_araddr, tam_pkg::PEAK_OFF))
				n.rdata = sext32(r.peak);
			else if (addr_is(s_axi_araddr, tam_pkg::MIN_OFF))
				n.rdata = sext32(r.minimum);
			else if (addr_is(s_axi_araddr, tam_pkg::CAL_OFF))
				n.rdata = sext32(r.cal);
			else if (!addr_is(s_axi_araddr, tam_pkg::CTRL_OFF))
				n.rresp = tam_pkg::RESP_SLVERR;
		end
	end

	// state register with synchronous reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= '0;
			r.upper <= tam_pkg::UPPER_RST;
			r.lower <= tam_pkg::LOWER_RST;
			r.cal <= tam_pkg::CAL_RST;
			r.temp <= tam_pkg::TEMP_RST;
			r.peak <= tam_pkg::TEMP_RST;
			r.minimum <= tam_pkg::TEMP_RST;
			r.display_value <= tam_pkg::TEMP_RST;
			r.display_on <= 1'b1;
		end
		else
			r <= n;
	end

	// bus handshakes and panel outputs
	assign s_axi_awready = !r.aw_held && !r.bvalid;
	assign s_axi_wready = !r.w_held && !r.bvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign display_value = r.display_value;
	assign display_item = r.menu;
	assign display_blank = r.display_blank;
	assign display_on = r.display_on;
	assign battery_dots = r.battery;
	assign relay_drive = r.relay;
	assign audible_drive = r.audible;
endmodule
`default_nettype wire

// ---- rtl/tam_pkg.sv ----
/*
 package for the cabinet temperature monitor: register map, field positions,
 reset values, temperature limits, timing constants and the menu states.
 assumes a 125 mhz clock and 32-bit axi4-lite access.
*/
package tam_pkg;
	// clock and the one-second tick
	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_S = 1;
	localparam int SEC_CYCLES = CLK_HZ * TICK_S;
	localparam int SECONDS_PER_MIN = 60;

	// times in their own units
	localparam int MENU_TIMEOUT_S = 15;
	localparam int ALARM_DELAY_MIN = 45;
	localparam int SILENCE_SHORT_MIN = 5;
	localparam int SILENCE_LONG_MIN = 45;

	// tick counts for the second timers; menu limit is one more so idle time exceeds 15 s
	localparam int TIMER_W = 12;
	localparam logic [11:0] MENU_IDLE_TICKS = 12'((MENU_TIMEOUT_S + 1) / TICK_S);
	localparam logic [11:0] ALARM_DELAY_TICKS = 12'(ALARM_DELAY_MIN * SECONDS_PER_MIN / TICK_S);
	localparam logic [11:0] SILENCE_SHORT_TICKS = 12'(SILENCE_SHORT_MIN * SECONDS_PER_MIN / TICK_S);
	localparam logic [11:0] SILENCE_LONG_TICKS = 12'(SILENCE_LONG_MIN * SECONDS_PER_MIN / TICK_S);

	// temperatures are signed whole degrees
	typedef logic signed [9:0] tam_temp_t;
	localparam tam_temp_t TEMP_MIN = -10'sd40;
	localparam tam_temp_t TEMP_MAX = 10'sd199;
	localparam tam_temp_t CAL_MIN = -10'sd30;
	localparam tam_temp_t CAL_MAX = 10'sd30;

	// values after reset (plain defaults)
	localparam tam_temp_t UPPER_RST = 10'sd45;
	localparam tam_temp_t LOWER_RST = -10'sd10;
	localparam tam_temp_t CAL_RST = 10'sd0;
	localparam tam_temp_t TEMP_RST = 10'sd0;

	// press vector positions, shared by the buttons and the control register
	localparam int PRESS_SET = 0;
	localparam int PRESS_UP = 1;
	localparam int PRESS_DOWN = 2;
	localparam int PRESS_RESET = 3;

	// option switch positions
	localparam int SW_DELAY = 0;
	localparam int SW_MANUAL = 1;
	localparam int SW_SIL_LONG = 2;
	localparam int SW_SIL_SHORT = 3;

	// register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] TEMP_OFF = 8'h08;
	localparam logic [7:0] UPPER_OFF = 8'h0c;
	localparam logic [7:0] LOWER_OFF = 8'h10;
	localparam logic [7:0] PEAK_OFF = 8'h14;
	localparam logic [7:0] MIN_OFF = 8'h18;
	localparam logic [7:0] CAL_OFF = 8'h1c;

	// status register fields
	localparam int ST_ALARM = 0;
	localparam int ST_AUDIBLE = 1;
	localparam int ST_SILENCED = 2;
	localparam int ST_OUT_RANGE = 3;
	localparam int ST_ITEM_LSB = 4;
	localparam int ST_MAINS_LOST = 7;
	localparam int ST_POWER_SHOW = 8;
	localparam int ST_BATTERY = 9;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// display items, in set-press order
	typedef enum logic [2:0] {
		SHOW_TEMP,
		SHOW_UPPER,
		SHOW_LOWER,
		SHOW_PEAK,
		SHOW_MIN,
		SHOW_CAL,
		SHOW_CONFIRM
	} tam_menu_e;
endpackage

// ---- rtl/tam_sec_timer.sv ----
/*
 second-tick timer: counts one-second ticks while run is high and raises
 done once limit ticks have passed. assumes tick is a one-cycle pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_sec_timer (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic tick, // one-second pulse
	input wire logic run, // count while high, clear while low
	input wire logic [11:0] limit, // ticks until done
	output logic done // level, high once limit reached
);
	typedef struct packed {
		logic [11:0] count;
		logic done;
	} tam_timer_s;

	tam_timer_s r;
	tam_timer_s n;

	// count ticks and hold at the limit
	always_comb
	begin
		n = r;
		if (!run)
		begin
			n.count = '0;
			n.done = 1'b0;
		end
		else
		begin
			if (tick && r.count != limit)
				n.count = r.count + 12'h1;
			n.done = (n.count == limit);
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	assign done = r.done;
endmodule
`default_nettype wire

// ---- sim/tam_panel_model.sv ----
/*
 front panel and sensor model: four buttons and the sensor word.
 assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_panel_model (
	input wire logic clk, // system clock
	output logic [3:0] btn, // set, up, down, reset
	output logic signed [9:0] temp, // sensor word
	output logic tvalid // sensor strobe
);
	// one press: a rising edge, held two cycles, then two released
	task automatic press(input int b);
		btn[b] <= 1'b1;
		repeat (2) @(posedge clk);
		btn[b] <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// one sensor word; the data line is scrambled once the strobe drops
	task automatic sense(input logic signed [9:0] t);
		temp <= t;
		tvalid <= 1'b1;
		@(posedge clk);
		temp <= ~t;
		tvalid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// idle panel at time zero
	initial
	begin
		btn = 4'h0;
		temp = 10'sd0;
		tvalid = 1'b0;
	end
endmodule
`default_nettype wire

// ---- sim/tam_monitor_chk.sv ----
/*
 port checker for the temperature monitor.
 assumes one clock, aclk, and aresetn synchronous active low.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_monitor_chk #(
	parameter int TICK_CYCLES = 10 // cycles per tick
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic button_set, // in
	input wire logic button_up, // in
	input wire logic button_down, // in
	input wire logic button_reset, // in
	input wire logic [3:0] option_sw, // in
	input wire logic battery_low, // in
	input wire logic mains_lost, // in
	input wire logic [2:0] display_item, // out
	input wire logic display_blank, // out
	input wire logic battery_dots, // out
	input wire logic relay_drive, // out
	input wire logic audible_drive // out
);
	localparam int IDLE_MAX = 17 * TICK_CYCLES + 4;
	int idle_reg;
	int idle_next;

	// cycles spent in the menu with no button held
	always_comb
	begin
		idle_next = 0;
		if (display_item != 3'h0 && !(button_set | button_up | button_down | button_reset))
			idle_next = idle_reg + 1;
	end
	always_ff @(posedge aclk)
		idle_reg <= aresetn ? idle_next : 0;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_menu_idle: assert property (idle_reg <= IDLE_MAX)
		else $error("menu stayed open too long");
	a_item_first: assert property ($rose(button_set) && display_item == 3'h0
		|-> ##[1:2] display_item == 3'h1) else $error("set press did not open menu");
	a_item_commit: assert property ($rose(button_set) && display_item == 3'h5
		|-> ##[1:2] display_item == 3'h6) else $error("last set press did not confirm");
	a_confirm_flash: assert property ($rose(display_item == 3'h6)
		|-> ##[0:1] display_blank) else $error("no confirm flash");
	a_dots_on: assert property (battery_low [*3] |-> battery_dots)
		else $error("battery dots dark");
	a_disabled_quiet: assert property ((option_sw[3:2] == 2'h3 && !mains_lost) [*3]
		|-> !relay_drive && !audible_drive) else $error("disabled alarm drove outputs");
	a_reset_silence: assert property ($rose(button_reset) && audible_drive
		&& !option_sw[1] && !mains_lost |-> ##[1:3] !audible_drive)
		else $error("reset press left sound on");
	a_relay_audible: assert property ($rose(relay_drive) |-> audible_drive)
		else $error("relay without sound");
endmodule
bind tam_monitor tam_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.aclk, .aresetn,
	.button_set, .button_up, .button_down, .button_reset, .option_sw, .battery_low,
	.mains_lost, .display_item, .display_blank, .battery_dots, .relay_drive, .audible_drive);
`default_nettype wire

// ---- sim/tam_monitor_bench.sv ----
/*
 bench for the temperature monitor: axi4-lite master, panel model, queued
 bus expectations. assumes a ten-cycle tick to shorten the long timers.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_monitor_bench;
	localparam int TK = 10;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] btn;
	logic [3:0] option_sw = 4'h0;
	logic signed [9:0] sensor_temp, display_value;
	logic sensor_valid, battery_low = 1'b0, mains_lost = 1'b0;
	logic [2:0] display_item;
	logic display_blank, display_on, battery_dots, relay_drive, audible_drive;
	logic [33:0] exp_q[$];
	int bad_count = 0;
	int checked = 0;

	// 125 mhz clock
	always #4 aclk = ~aclk;

	tam_panel_model pm (.clk(aclk), .btn(btn), .temp(sensor_temp), .tvalid(sensor_valid));
	tam_monitor #(.TICK_CYCLES(TK)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.button_set(btn[0]), .button_up(btn[1]), .button_down(btn[2]),
		.button_reset(btn[3]), .option_sw, .sensor_temp, .sensor_valid, .battery_low,
		.mains_lost, .display_value, .display_item, .display_blank, .display_on,
		.battery_dots, .relay_drive, .audible_drive);

	// count and report one comparison
	task automatic chk(input logic [33:0] seen, input logic [33:0] want);
		checked++;
		if (seen !== want)
		begin
			bad_count++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic hang();
		bad_count++;
		$display("ERROR %0t: bus answer never came", $time);
		end_of_test();
	endtask

	function automatic logic [33:0] okv(input int v);
		return {2'h0, v[31:0]};
	endfunction

	// watcher: each bus answer against the oldest queued note
	always @(posedge aclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
	end

	// one write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		exp_q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		if (i == 50)
			hang();
	endtask

	// one read
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int i;
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		if (i == 50)
			hang();
	endtask

	// main sequence
	initial
	begin
		int i;
		int k;
		int t;
		int hi;
		int lo;
		int step[6] = '{0, 2, -1, 0, 0, 35};
		int want[6] = '{0, 47, -11, 0, 0, 30};
		logic [3:0] sw_t[4] = '{4'hc, 4'h8, 4'h4, 4'h1};
		int n_t[4] = '{0, 300, 2700, 2700};
		logic [3:0] r_t[4] = '{4'b0000, 4'b1110, 4'b1110, 4'b0011};
		void'($urandom(34));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h0c, okv(45));
		rd(8'h10, okv(-10));
		rd(8'h40, {2'h2, 32'h0});
		wr(8'h20, 32'h1, 2'h2);
		// control write with byte lane 0 off is accepted but presses nothing
		s_axi_wstrb <= 4'h0;
		wr(8'h00, 32'h1, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(8'h04, okv(0));
		$display("registers test done");
		// walk the menu, edit, clamp the offset at its top and commit
		pm.sense(10'sd20);
		for (i = 1; i < 7; i++)
		begin
			pm.press(tam_pkg::PRESS_SET);
			if (i < 6)
				chk(display_item, i);
			for (k = 0; i < 6 && k < (step[i] < 0 ? -step[i] : step[i]); k++)
				pm.press(step[i] > 0 ? tam_pkg::PRESS_UP : tam_pkg::PRESS_DOWN);
			if (i < 6 && step[i] != 0)
				chk(display_value, want[i]);
		end
		rd(8'h0c, okv(47));
		rd(8'h10, okv(-11));
		rd(8'h1c, okv(30));
		$display("menu test done");
		// calibrated 50 is above the upper threshold of 47
		pm.sense(10'sd20);
		rd(8'h08, okv(50));
		chk({relay_drive, audible_drive}, 2'b11);
		pm.sense(10'sd10);
		chk(relay_drive, 1'b0);
		// manual mode holds the alarm until a reset press
		option_sw <= 4'h2;
		pm.sense(10'sd20);
		pm.sense(10'sd10);
		chk(relay_drive, 1'b1);
		pm.press(tam_pkg::PRESS_RESET);
		chk(relay_drive, 1'b0);
		// automatic mode: reset press only silences
		option_sw <= 4'h0;
		pm.sense(10'sd20);
		pm.press(tam_pkg::PRESS_RESET);
		chk({relay_drive, audible_drive}, 2'b10);
		pm.sense(10'sd10);
		$display("alarm test done");
		// disable, short and long silencing, alarm delay
		for (i = 0; i < 4; i++)
		begin
			option_sw <= sw_t[i];
			pm.sense(10'sd20);
			repeat ((n_t[i] - 2) * TK) @(posedge aclk);
			chk({relay_drive, audible_drive}, r_t[i][3:2]);
			if (i == 0)
				chk(display_blank, 1'b0);
			repeat (4 * TK) @(posedge aclk);
			chk({relay_drive, audible_drive}, r_t[i][1:0]);
			pm.sense(10'sd10);
		end
		$display("timer test done");
		// logs: reset press restarts them from the shown temperature
		option_sw <= 4'hc;
		pm.press(tam_pkg::PRESS_RESET);
		hi = 40;
		lo = 40;
		for (i = 0; i < 8; i++)
		begin
			t = int'($urandom_range(130));
			hi = t > hi ? t : hi;
			lo = t < lo ? t : lo;
			pm.sense(10'(t - 30));
		end
		rd(8'h14, okv(hi));
		rd(8'h18, okv(lo));
		pm.press(tam_pkg::PRESS_RESET);
		rd(8'h14, okv(t));
		$display("log test done");
		// battery dots, power loss display
		option_sw <= 4'h0;
		battery_low <= 1'b1;
		mains_lost <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(battery_dots, 1'b1);
		pm.press(tam_pkg::PRESS_RESET);
		chk({display_on, audible_drive}, 2'b11);
		mains_lost <= 1'b0;
		battery_low <= 1'b0;
		// set press by register, then the menu times out and drops the edit
		wr(8'h00, 32'h1, 2'h0);
		repeat (4) @(posedge aclk);
		chk(display_item, 3'h1);
		pm.press(tam_pkg::PRESS_UP);
		repeat (20 * TK) @(posedge aclk);
		chk(display_item, 3'h0);
		rd(8'h0c, okv(47));
		$display("power and timeout test done");
		end_of_test();
	end
endmodule
`default_nettype wire
